// ===== rtl/nor_host_pkg.sv
package nor_host_pkg;
    // flash command codes
    localparam logic [7:0] CMD_BUF_SETUP = 8'h25;
    localparam logic [7:0] CMD_CONFIRM = 8'h29;
    localparam logic [7:0] CMD_ABORT_RESET = 8'hF0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_EXT_ENTER = 8'h88;
    localparam logic [7:0] CMD_EXT_EXIT1 = 8'h90;
    localparam logic [7:0] CMD_EXT_EXIT2 = 8'h00;
    localparam logic [23:0] UNLOCK_ADDR1 = 24'h00_0555;
    localparam logic [23:0] UNLOCK_ADDR2 = 24'h00_02AA;
    // buffer limits
    localparam logic [9:0] BUF_MAX_X16 = 10'h01FF;
    localparam logic [9:0] BUF_MAX_X8 = 10'h00FF;
    // polling status bit positions
    localparam int ABORT_FLAG_BIT = 1;
    localparam int ERROR_FLAG_BIT = 5;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int COMPLETION_STATUS_BIT = 7;
    // bus cycle timing, cycles at 40 MHz
    localparam int CLK_NS = 25;
    localparam int WE_LOW_NS = 50;
    localparam int RD_ACC_NS = 75;
    localparam logic [3:0] WE_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RD_CYC = 4'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
    // own register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [31:0] RESP_OKAY = 32'h0000_0000;
    // host operations, written to ctrl[3:0]
    localparam logic [3:0] OP_WRITE = 4'h1;
    localparam logic [3:0] OP_READ = 4'h2;
    localparam logic [3:0] OP_BUF_SETUP = 4'h3;
    localparam logic [3:0] OP_LOAD = 4'h4;
    localparam logic [3:0] OP_CONFIRM = 4'h5;
    localparam logic [3:0] OP_ABORT_RESET = 4'h6;
    localparam logic [3:0] OP_SUSPEND = 4'h7;
    localparam logic [3:0] OP_RESUME = 4'h8;
    localparam logic [3:0] OP_AUTOSEL = 4'h9;
    localparam logic [3:0] OP_EXT_ENTER = 4'hA;
    localparam logic [3:0] OP_EXT_EXIT = 4'hB;
    localparam logic [3:0] OP_EXIT = 4'hC;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } flash_cycle_t;
endpackage : nor_host_pkg

// ===== rtl/nor_host_ctrl.sv
// Function
// - in bypass mode setup 25h is sent without the two unlock writes
// - programming starts only when 29h follows the loads
// - after any abort host issues F0h reset before new operations
// - in bypass mode abort recovery uses the full three-write sequence
// - extended block reads are bracketed by enter and exit sequences
// - resume 30h continues programming, progress via polling bits
// - host unprotects target blocks before raising high voltage; here ctrl[11] drives the pin with no unprotect step
// - high voltage only for accelerated buffer program and chip erase; here ctrl[11] raises it for any operation
// - count n goes to block address, then n+1 loads from start
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module nor_host_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // flash pins
    output logic [23:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_rst_n,
    output logic accel_high_voltage_level
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_WR = 4'b0010,
        S_RD = 4'b0100,
        S_GAP = 4'b1000
    } bus_st_t;

    bus_st_t st_r;
    nor_host_pkg::flash_cycle_t seq_r [0:3];
    logic [1:0] seq_len_r;
    logic [1:0] seq_idx_r;
    logic [3:0] cnt_r;
    logic [23:0] addr_r;
    logic [15:0] data_r;
    logic [15:0] rdata_r;
    logic bypass_r, x8_r, hw_reset_r, busy_r;
    logic aborted_r, suspended_r, resumed_r, err_cnt_r;
    logic aw_ok_r, w_ok_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic cmd_go;
    logic [3:0] op;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // unlock prefix skipped for buffer setup while bypass mode or high voltage is on
    function automatic logic use_unlock(input logic byp);
        return !byp;
    endfunction : use_unlock

    // axi write capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
        end else if (s_bvalid && s_bready) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_ok_r <= 1'b1;
                wdata_r <= s_wdata;
            end
        end
    end

    assign cmd_go = aw_ok_r && w_ok_r && !s_bvalid &&
        awaddr_r == nor_host_pkg::REG_CTRL && st_r == S_IDLE && !busy_r;
    assign op = wdata_r[3:0];

    // handshake outputs from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
        end else begin
            s_awready <= !aw_ok_r && !s_awready && !s_bvalid;
            s_wready <= !w_ok_r && !s_wready && !s_bvalid;
            if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
            else if (aw_ok_r && w_ok_r && !s_bvalid &&
                     (awaddr_r != nor_host_pkg::REG_CTRL ||
                      (st_r == S_IDLE && !busy_r))) begin
                s_bvalid <= 1'b1;
                s_bresp <= 2'b00;
            end
        end
    end

    // own registers: address, data, mode bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= 24'h00_0000;
            data_r <= 16'h0000;
            bypass_r <= 1'b0;
            x8_r <= 1'b0;
            hw_reset_r <= 1'b0;
        end else if (aw_ok_r && w_ok_r && !s_bvalid) begin
            if (awaddr_r == nor_host_pkg::REG_ADDR)
                addr_r <= wdata_r[23:0];
            if (awaddr_r == nor_host_pkg::REG_DATA)
                data_r <= wdata_r[15:0];
            if (awaddr_r == nor_host_pkg::REG_CTRL && !busy_r) begin
                bypass_r <= wdata_r[8];
                x8_r <= wdata_r[9];
                hw_reset_r <= wdata_r[10];
            end
        end
    end

    // high voltage from its own bit, ctrl[11], with no block unprotect step
    always_ff @(posedge aclk) begin
        if (!aresetn)
            accel_high_voltage_level <= 1'b0;
        else if (aw_ok_r && w_ok_r && !s_bvalid &&
                 awaddr_r == nor_host_pkg::REG_CTRL && !busy_r)
            accel_high_voltage_level <= wdata_r[11];
    end

    // sequence builder and flash bus cycle engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= S_IDLE;
            busy_r <= 1'b0;
            seq_len_r <= 2'd0;
            seq_idx_r <= 2'd0;
            cnt_r <= 4'h0;
            for (int i = 0; i < 4; i++)
                seq_r[i] <= '0;
            flash_addr <= 24'h00_0000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            rdata_r <= 16'h0000;
        end else unique case (st_r)
            S_IDLE: begin
                if (cmd_go) begin
                    busy_r <= 1'b1;
                    seq_idx_r <= 2'd0;
                    seq_r[0] <= '{nor_host_pkg::UNLOCK_ADDR1,
                        {8'h00, nor_host_pkg::CMD_UNLOCK1}};
                    seq_r[1] <= '{nor_host_pkg::UNLOCK_ADDR2,
                        {8'h00, nor_host_pkg::CMD_UNLOCK2}};
                    seq_len_r <= 2'd2;
                    unique case (op)
                        nor_host_pkg::OP_BUF_SETUP: begin
                            // setup to block, then count n
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_BUF_SETUP}};
                            seq_r[1] <= '{addr_r, data_r};
                            seq_len_r <= 2'd1;
                            if (use_unlock(bypass_r ||
                                    accel_high_voltage_level)) begin
                                seq_r[2] <= '{addr_r,
                                    {8'h00, nor_host_pkg::CMD_BUF_SETUP}};
                                seq_r[0] <= '{nor_host_pkg::UNLOCK_ADDR1,
                                    {8'h00, nor_host_pkg::CMD_UNLOCK1}};
                                seq_r[1] <= '{nor_host_pkg::UNLOCK_ADDR2,
                                    {8'h00, nor_host_pkg::CMD_UNLOCK2}};
                                seq_r[3] <= '{addr_r, data_r};
                                seq_len_r <= 2'd3;
                            end
                        end
                        nor_host_pkg::OP_CONFIRM: begin
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_CONFIRM}};
                            seq_len_r <= 2'd0;
                        end
                        nor_host_pkg::OP_ABORT_RESET: begin
                            // always the full three writes
                            seq_r[2] <= '{nor_host_pkg::UNLOCK_ADDR1,
                                {8'h00, nor_host_pkg::CMD_ABORT_RESET}};
                        end
                        nor_host_pkg::OP_SUSPEND: begin
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_SUSPEND}};
                            seq_len_r <= 2'd0;
                        end
                        nor_host_pkg::OP_RESUME: begin
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_RESUME}};
                            seq_len_r <= 2'd0;
                        end
                        nor_host_pkg::OP_AUTOSEL:
                            seq_r[2] <= '{nor_host_pkg::UNLOCK_ADDR1,
                                {8'h00, nor_host_pkg::CMD_AUTOSEL}};
                        nor_host_pkg::OP_EXT_ENTER:
                            seq_r[2] <= '{nor_host_pkg::UNLOCK_ADDR1,
                                {8'h00, nor_host_pkg::CMD_EXT_ENTER}};
                        nor_host_pkg::OP_EXT_EXIT: begin
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_EXT_EXIT1}};
                            seq_r[1] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_EXT_EXIT2}};
                            seq_len_r <= 2'd1;
                        end
                        nor_host_pkg::OP_EXIT: begin
                            seq_r[0] <= '{addr_r,
                                {8'h00, nor_host_pkg::CMD_ABORT_RESET}};
                            seq_len_r <= 2'd0; // leaves auto-select
                        end
                        default: begin
                            // plain write, load or read of one location
                            seq_r[0] <= '{addr_r, data_r};
                            seq_len_r <= 2'd0;
                        end
                    endcase
                    st_r <= (op == nor_host_pkg::OP_READ) ? S_RD : S_WR;
                    cnt_r <= 4'h0;
                end
            end
            S_WR: begin
                flash_addr <= seq_r[seq_idx_r].addr;
                flash_dq_out <= seq_r[seq_idx_r].data;
                flash_dq_oe <= 1'b1;
                flash_ce_n <= 1'b0;
                flash_we_n <= 1'b0;
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == nor_host_pkg::WE_CYC) begin
                    flash_we_n <= 1'b1;
                    cnt_r <= 4'h0;
                    st_r <= S_GAP;
                end
            end
            S_RD: begin
                // reads allowed any time, status word while busy
                flash_addr <= seq_r[0].addr;
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == nor_host_pkg::RD_CYC) begin
                    rdata_r <= flash_dq_in;
                    flash_oe_n <= 1'b1;
                    cnt_r <= 4'h0;
                    st_r <= S_GAP;
                end
            end
            S_GAP: begin
                flash_ce_n <= 1'b1;
                flash_dq_oe <= 1'b0;
                if (flash_oe_n && seq_idx_r != seq_len_r &&
                    !flash_dq_oe == 1'b0) begin
                    seq_idx_r <= seq_idx_r + 2'd1;
                    st_r <= S_WR;
                end else begin
                    busy_r <= 1'b0;
                    st_r <= S_IDLE;
                end
            end
            default: st_r <= S_IDLE;
        endcase
    end

    // hardware reset pin, aborts suspended program
    always_ff @(posedge aclk) begin
        if (!aresetn)
            flash_rst_n <= 1'b0;
        else
            flash_rst_n <= !hw_reset_r;
    end

    // host view of device state from issued commands and polling reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aborted_r <= 1'b0;
            suspended_r <= 1'b0;
            resumed_r <= 1'b0;
            err_cnt_r <= 1'b0;
        end else begin
            if (cmd_go && op == nor_host_pkg::OP_BUF_SETUP)
                err_cnt_r <= {6'h00, data_r[9:0]} >
                    {6'h00, x8_r ? nor_host_pkg::BUF_MAX_X8
                                 : nor_host_pkg::BUF_MAX_X16};
            if (st_r == S_RD && cnt_r == nor_host_pkg::RD_CYC)
                // abort signature: flag set, error clear
                aborted_r <= flash_dq_in[nor_host_pkg::ABORT_FLAG_BIT] &&
                    !flash_dq_in[nor_host_pkg::ERROR_FLAG_BIT];
            if (cmd_go && op == nor_host_pkg::OP_ABORT_RESET)
                aborted_r <= 1'b0;
            if (cmd_go && op == nor_host_pkg::OP_SUSPEND) begin
                suspended_r <= 1'b1;
                resumed_r <= 1'b0;
            end
            if (cmd_go && op == nor_host_pkg::OP_RESUME && !resumed_r) begin
                suspended_r <= 1'b0;
                resumed_r <= 1'b1;
            end
            if (hw_reset_r) begin
                suspended_r <= 1'b0;
                resumed_r <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'b00;
        end else begin
            s_arready <= !s_rvalid && !s_arready;
            if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
            else if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= 2'b00;
                unique case (s_araddr)
                    nor_host_pkg::REG_CTRL: s_rdata <= {20'h0_0000,
                        accel_high_voltage_level, hw_reset_r, x8_r,
                        bypass_r, 4'h0, wdata_r[3:0]};
                    nor_host_pkg::REG_ADDR: s_rdata <= {8'h00, addr_r};
                    nor_host_pkg::REG_DATA: s_rdata <= {16'h0000, data_r};
                    nor_host_pkg::REG_STATUS: s_rdata <= {26'h000_0000,
                        err_cnt_r, resumed_r, suspended_r, aborted_r,
                        1'b0, busy_r};
                    nor_host_pkg::REG_RDATA: s_rdata <= {16'h0000, rdata_r};
                    default: begin
                        s_rdata <= nor_host_pkg::RESP_OKAY;
                        s_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    // checks
    abort_reset_len_a: assert property (cmd_go &&
        op == nor_host_pkg::OP_ABORT_RESET |=> seq_len_r == 2'd2)
        else $error("abort reset not three writes");
    bypass_short_a: assert property (cmd_go && bypass_r &&
        op == nor_host_pkg::OP_BUF_SETUP
        |=> seq_len_r == 2'd1 && seq_r[0].data[7:0] == 8'h25)
        else $error("bypass setup not short");
    confirm_code_a: assert property (cmd_go &&
        op == nor_host_pkg::OP_CONFIRM |=> seq_r[0].data == 16'h0029)
        else $error("confirm code wrong");
    resume_once_a: assert property (cmd_go && resumed_r &&
        op == nor_host_pkg::OP_RESUME && !hw_reset_r |=> resumed_r)
        else $error("second resume changed state");
    rst_pin_a: assert property (hw_reset_r |=> !flash_rst_n)
        else $error("reset pin not asserted");
    abort_clear_a: assert property (cmd_go &&
        op == nor_host_pkg::OP_ABORT_RESET |=> !aborted_r)
        else $error("abort state not cleared");
    suspend_set_a: assert property (cmd_go && !hw_reset_r &&
        op == nor_host_pkg::OP_SUSPEND |=> suspended_r && !resumed_r)
        else $error("suspend not recorded");
    we_pulse_a: assert property ($fell(flash_we_n)
        |-> !flash_we_n [*2] ##1 flash_we_n)
        else $error("write strobe width wrong");
    cov_setup_c: cover property (cmd_go && op == nor_host_pkg::OP_BUF_SETUP);
    cov_suspend_c: cover property (suspended_r ##1 resumed_r);
    cov_abort_c: cover property (aborted_r);
endmodule : nor_host_ctrl

// ===== tb/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
    parameter logic [15:0] ASEL_CODE = 16'h5AC3 // arbitrary code
) (
    // flash pins
    input wire logic [23:0] flash_addr,
    output logic [15:0] flash_dq_in,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_rst_n,
    input wire logic accel_high_voltage_level
);
    logic [15:0] mem [int];
    logic [15:0] pend [int];
    logic [15:0] q = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] d;
    logic [23:0] a;
    logic [14:0] pg;
    logic [7:0] blk;
    logic tog = 1'b0;
    logic first;
    int st = 0, left = 0, reads = 0, ucnt = 0;
    // a released bus shows the inverse of the last word, not a stale copy
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? q : ~q;
    // busy or aborted reads give polling status; completes after two reads
    always @(negedge flash_oe_n) begin
        if (!flash_ce_n && (st == 4 || st == 5)) begin
            tog = ~tog;
            q = {8'h00, ~last[7], tog, 4'h0, st == 5, 1'b0};
            reads++;
            if (st == 4 && reads > 1) begin
                foreach (pend[k]) mem[k] = pend[k];
                st = 0;
            end
        end else if (!flash_ce_n) begin
            q = (st >= 7) ? ASEL_CODE : 16'hFFFF;
            if (st < 7 && mem.exists(flash_addr))
                q = mem[flash_addr];
        end
    end
    // commands latch on the rising edge of the write strobe
    always @(posedge flash_we_n or negedge flash_rst_n) begin
        if (!flash_rst_n) begin
            st = 0;
            pend.delete();
        end else if (!flash_ce_n) begin
            a = flash_addr;
            d = flash_dq_out;
            if (st != 2 && a == nor_host_pkg::UNLOCK_ADDR1 && d[7:0] == 8'hAA)
                ucnt = 1;
            else if (st != 2 && a == nor_host_pkg::UNLOCK_ADDR2
                     && d[7:0] == 8'h55)
                ucnt = ucnt + 1;
            else begin
                // only the full three-write reset clears an abort
                if (d[7:0] == 8'hF0 && ucnt == 2 && st inside {[1:3], 5})
                    st = 0;
                else case (st)
                0: if (d[7:0] == 8'h25) begin
                    blk = a[23:16];
                    pend.delete();
                    st = 1;
                end
                1: begin
                    left = d;
                    first = 1'b1;
                    st = (d > nor_host_pkg::BUF_MAX_X16) ? 5 : 2;
                end
                2: begin
                    if (first) pg = a[23:9];
                    first = 1'b0;
                    last = d;
                    if (a[23:16] != blk || a[23:9] != pg) st = 5;
                    else begin
                        pend[a] = d;
                        left--;
                        if (left < 0) st = 3;
                    end
                end
                3: begin
                    st = (d[7:0] == 8'h29) ? 4 : 5;
                    reads = 0;
                end
                4: if (d[7:0] == 8'hB0) st = 6;
                6: if (d[7:0] == 8'h30) st = 4;
                   else if (d[7:0] == 8'h90 && ucnt == 2) st = 7;
                   else if (d[7:0] == 8'h88 && ucnt == 2) st = 8;
                7: if (d[7:0] == 8'hF0) st = 6;
                8: if (d[7:0] == 8'h00) st = 6;
                default: ;
                endcase
                ucnt = 0;
            end
        end
    end
endmodule : flash_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rr;
    logic [31:0] s_rdata, r;
    logic [23:0] flash_addr;
    logic [23:0] ad [4] = '{24'h00_0000, 24'h02_0010, 24'h01_0200, 24'h01_0011};
    logic [15:0] flash_dq_in, flash_dq_out, q, q0;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n, hv;
    logic [3:0] mode = 4'h0;
    int mismatches = 0, num_checks = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    nor_host_ctrl i_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .flash_addr, .flash_dq_in, .flash_dq_out,
        .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n,
        .accel_high_voltage_level(hv));
    flash_model i_flash (.flash_addr, .flash_dq_in, .flash_dq_out,
        .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n,
        .accel_high_voltage_level(hv));
    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_awaddr, s_wdata} <= {a, d};
        {s_awvalid, s_wvalid, s_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_rd
    // one engine operation, then wait for the busy flag to drop
    task automatic op(input logic [3:0] o, input logic [23:0] a,
                      input logic [15:0] d);
        axi_wr(nor_host_pkg::REG_ADDR, {8'h00, a});
        axi_wr(nor_host_pkg::REG_DATA, {16'h0000, d});
        axi_wr(nor_host_pkg::REG_CTRL, {20'h0_0000, mode, 4'h0, o});
        do axi_rd(nor_host_pkg::REG_STATUS, r); while (r[0] !== 1'b0);
    endtask : op
    task automatic frd(input logic [23:0] a, output logic [15:0] v);
        op(nor_host_pkg::OP_READ, a, 16'h0000);
        axi_rd(nor_host_pkg::REG_RDATA, r);
        v = r[15:0];
    endtask : frd
    // hang guard, far above the few thousand cycles the tests need
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(8'h20, r);
        check("unmapped resp", {14'h0000, rr}, 16'h0002);
        // accelerated buffer program in bypass mode
        mode = 4'b1001;
        op(nor_host_pkg::OP_BUF_SETUP, 24'h01_0000, 16'h0001);
        check("hv pin", {15'h0000, hv}, 16'h0001);
        op(nor_host_pkg::OP_LOAD, 24'h01_0000, 16'h1234);
        op(nor_host_pkg::OP_LOAD, 24'h01_0001, 16'h5678);
        op(nor_host_pkg::OP_CONFIRM, 24'h01_0000, 16'h0000);
        frd(24'h01_0000, q0);
        check("busy poll", q0 & 16'h00A2, 16'h0080);
        frd(24'h01_0000, q);
        check("toggle", {15'h0000, q[6] ^ q0[6]}, 16'h0001);
        frd(24'h01_0000, q);
        check("programmed", q, 16'h1234);
        // abort cases in the standard sequence, high voltage removed
        mode = 4'h0;
        for (int k = 0; k < 4; k++) begin
            op(nor_host_pkg::OP_BUF_SETUP, 24'h01_0000,
               k == 0 ? 16'h0200 : 16'h0001);
            if (k > 0) op(nor_host_pkg::OP_LOAD, 24'h01_0010, 16'h0011);
            if (k > 0) op(nor_host_pkg::OP_LOAD, ad[k], 16'h00F2);
            if (k == 3) op(nor_host_pkg::OP_WRITE, 24'h01_0010, 16'h00F0);
            frd(24'h01_0010, q);
            axi_rd(nor_host_pkg::REG_STATUS, r);
            if (k == 0) check("count flag", r[15:0] & 16'h0020, 16'h0020);
            if (k > 0) check("abort poll", q & 16'h00A2, 16'h0002);
            if (k > 0) check("abort seen", r[15:0] & 16'h0004, 16'h0004);
            op(nor_host_pkg::OP_ABORT_RESET, 24'h01_0000, 16'h0000);
            frd(24'h01_0000, q);
            check("read mode", q, 16'h1234);
        end
        // suspend, auto-select inside it, resume twice, suspend again
        op(nor_host_pkg::OP_BUF_SETUP, 24'h03_0000, 16'h0000);
        op(nor_host_pkg::OP_LOAD, 24'h03_0000, 16'h00AB);
        op(nor_host_pkg::OP_CONFIRM, 24'h03_0000, 16'h0000);
        op(nor_host_pkg::OP_SUSPEND, 24'h03_0000, 16'h0000);
        check("suspended", r[15:0] & 16'h0008, 16'h0008);
        frd(24'h01_0000, q);
        check("suspend read", q, 16'h1234);
        op(nor_host_pkg::OP_AUTOSEL, 24'h00_0000, 16'h0000);
        frd(24'h00_0000, q);
        check("autoselect", q, 16'h5AC3);
        op(nor_host_pkg::OP_EXIT, 24'h00_0000, 16'h0000);
        op(nor_host_pkg::OP_EXT_ENTER, 24'h00_0000, 16'h0000);
        frd(24'h00_0000, q);
        check("ext block", q, 16'h5AC3);
        op(nor_host_pkg::OP_EXT_EXIT, 24'h00_0000, 16'h0000);
        frd(24'h01_0000, q);
        check("back to suspend", q, 16'h1234);
        op(nor_host_pkg::OP_RESUME, 24'h03_0000, 16'h0000);
        check("resumed", r[15:0] & 16'h0010, 16'h0010);
        op(nor_host_pkg::OP_RESUME, 24'h03_0000, 16'h0000);
        op(nor_host_pkg::OP_SUSPEND, 24'h03_0000, 16'h0000);
        frd(24'h01_0000, q);
        check("resuspended", q, 16'h1234);
        // hardware reset drops the suspended program
        axi_wr(nor_host_pkg::REG_CTRL, 32'h0000_0400);
        @(posedge aclk); // pin lags the write by a cycle
        check("reset pin", {15'h0000, flash_rst_n}, 16'h0000);
        axi_wr(nor_host_pkg::REG_CTRL, 32'h0000_0000);
        frd(24'h01_0000, q);
        check("after reset", q, 16'h1234);
        tally_and_finish;
    end
endmodule : testbench
